//--- design/eeprom_host.sv
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
module eeprom_host
   import eeprom_host_pkg::*;
#(
   parameter int POR_CYCLES = POR_CYC,
   parameter int PROG_CYCLES = PROG_CYC,
   parameter logic [SEQ_LEN-1:0][ADDR_W-1:0] ON_ADDR =
      {17'h00003, 17'h00002, 17'h00001},
   parameter logic [SEQ_LEN-1:0][DATA_W-1:0] ON_DATA =
      {8'h03, 8'h02, 8'h01},
   parameter logic [SEQ_LEN-1:0][ADDR_W-1:0] OFF_ADDR =
      {17'h00006, 17'h00005, 17'h00004},
   parameter logic [SEQ_LEN-1:0][DATA_W-1:0] OFF_DATA =
      {8'h06, 8'h05, 8'h04}
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [DATA_W-1:0] dq_in,
   output mem_pins_type pins
);
   // timers are TMR_W wide; larger counts would wrap silently
   if (POR_CYCLES < 1 || POR_CYCLES >= (1 << TMR_W) ||
       PROG_CYCLES < 1 || PROG_CYCLES >= (1 << TMR_W)) begin : g_bad_timer
      $error("timer parameters out of range");
   end

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_SETUP = 3'b001,
      S_STROBE = 3'b010,
      S_RECOVER = 3'b011,
      S_READ = 3'b100,
      S_GAP = 3'b101,
      S_PROG = 3'b110
   } state_type;

   // =====================================================
   // registers
   state_type state_reg;
   logic [TMR_W-1:0] cnt_reg, por_reg, win_reg;
   logic [ADDR_W-1:0] addr_reg, cur_addr_reg, page_reg;
   logic [DATA_W-1:0] wdata_reg, cur_data_reg, rdata_reg, last_data_reg;
   logic [1:0] idx_reg;
   logic id_reg, lock_reg, poll_reg, seq_reg, lock_op_reg, on_op_reg;
   logic done_reg, refused_reg, prev6_reg, prev_ok_reg;

   // =====================================================
   // apb decode, zero wait states
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hit_ctrl = paddr == OFS_CTRL;
   wire hit_cmd = paddr == OFS_CMD;
   wire hit_addr = paddr == OFS_ADDR;
   wire hit_wdata = paddr == OFS_WDATA;
   wire hit_rdata = paddr == OFS_RDATA;
   wire hit_status = paddr == OFS_STATUS;
   wire mapped = hit_ctrl | hit_cmd | hit_addr | hit_wdata | hit_rdata |
                 hit_status;
   wire busy = state_reg != S_IDLE;
   wire por_done = por_reg == '0;
   wire load_open = win_reg != '0;
   wire [2:0] op = pwdata[2:0];
   wire go = wr & hit_cmd & ~busy;
   wire [31:0] status_word = {26'h0, lock_reg, refused_reg, done_reg,
                              load_open, por_done, busy};
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;
   assign prdata = !acc ? 32'h0 :
                   hit_ctrl ? {30'h0, lock_reg, id_reg} :
                   hit_addr ? {15'h0, addr_reg} :
                   hit_wdata ? {24'h0, wdata_reg} :
                   hit_rdata ? {24'h0, rdata_reg} :
                   hit_status ? status_word : 32'h0;

   // a write that leaves the open page is refused until the load window closes
   wire page_clash = load_open &&
                     addr_reg[ADDR_W-1:PAGE_LSB] !=
                     page_reg[ADDR_W-1:PAGE_LSB];
   // unlock prefix needed once per page load when locked
   wire need_prefix = lock_reg & ~load_open;
   wire write_ok = por_done & ~page_clash;
   wire last_byte = seq_reg ? idx_reg == 2'(SEQ_LEN - 1)
                            : idx_reg == 2'(SEQ_LEN);
   wire [1:0] idx_inc = idx_reg + 2'h1;
   wire [ADDR_W-1:0] nxt_addr = idx_inc == 2'(SEQ_LEN) ? addr_reg :
      (on_op_reg ? ON_ADDR[idx_inc] : OFF_ADDR[idx_inc]);
   wire [DATA_W-1:0] nxt_data = idx_inc == 2'(SEQ_LEN) ? wdata_reg :
      (on_op_reg ? ON_DATA[idx_inc] : OFF_DATA[idx_inc]);
   // polling ends when bit six holds still and bit seven matches the last written byte
   wire poll_end = prev_ok_reg && dq_in[6] == prev6_reg &&
                   dq_in[7] == last_data_reg[7];
   wire cnt_end = cnt_reg <= TMR_W'(1);

   // =====================================================
   // control pins decoded from state; address, data and id line from flops
   assign pins.addr = cur_addr_reg;
   assign pins.dq_out = cur_data_reg;
   assign pins.ce_n = ~(state_reg == S_SETUP || state_reg == S_STROBE ||
                        state_reg == S_READ);
   assign pins.oe_n = state_reg != S_READ;
   assign pins.we_n = state_reg != S_STROBE;
   assign pins.dq_oe = state_reg == S_SETUP || state_reg == S_STROBE ||
                       state_reg == S_RECOVER;
   assign pins.id_hv = id_reg;

   // =====================================================
   // software registers: id, address and write data
   always_ff @(posedge clk) begin
      if (reset) begin
         id_reg <= 1'b0;
         addr_reg <= '0;
         wdata_reg <= '0;
      end else begin
         if (wr && hit_ctrl) id_reg <= pwdata[CTRL_ID_BIT];
         if (wr && hit_addr && !busy) addr_reg <= pwdata[ADDR_W-1:0];
         if (wr && hit_wdata && !busy) wdata_reg <= pwdata[DATA_W-1:0];
      end
   end

   // =====================================================
   // power-on hold-off and byte-load window timers
   always_ff @(posedge clk) begin
      if (reset) begin
         por_reg <= TMR_W'(POR_CYCLES);
         win_reg <= '0;
      end else begin
         if (!por_done) por_reg <= por_reg - TMR_W'(1);
         // window restarts at each strobe release
         if (state_reg == S_STROBE && cnt_end)
            win_reg <= TMR_W'(BLW_CYC);
         else if (load_open)
            win_reg <= win_reg - TMR_W'(1);
      end
   end

   // =====================================================
   // sequencer
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= S_IDLE;
         cnt_reg <= '0;
         cur_addr_reg <= '0;
         cur_data_reg <= '0;
         rdata_reg <= '0;
         last_data_reg <= '0;
         page_reg <= '0;
         idx_reg <= '0;
         lock_reg <= 1'b0;
         poll_reg <= 1'b0;
         seq_reg <= 1'b0;
         lock_op_reg <= 1'b0;
         on_op_reg <= 1'b0;
         done_reg <= 1'b0;
         refused_reg <= 1'b0;
         prev6_reg <= 1'b0;
         prev_ok_reg <= 1'b0;
      end else begin
         // device lock is nonvolatile; software states it after boot
         if (wr && hit_ctrl && !busy)
            lock_reg <= pwdata[CTRL_LOCK_BIT];
         unique case (state_reg)
            S_IDLE: begin
               if (go && op == OP_READ) begin
                  cur_addr_reg <= addr_reg;
                  poll_reg <= 1'b0;
                  cnt_reg <= TMR_W'(ACC_CYC);
                  state_reg <= S_READ;
               end else if (go && op == OP_POLL) begin
                  cur_addr_reg <= page_reg;
                  poll_reg <= 1'b1;
                  prev_ok_reg <= 1'b0;
                  done_reg <= 1'b0;
                  cnt_reg <= TMR_W'(ACC_CYC);
                  state_reg <= S_READ;
               end else if (go && op == OP_WRITE) begin
                  if (write_ok) begin
                     // a prefixed load opens on the data byte's page
                     if (need_prefix) page_reg <= addr_reg;
                     seq_reg <= 1'b0;
                     on_op_reg <= 1'b1;
                     idx_reg <= need_prefix ? 2'h0 : 2'(SEQ_LEN);
                     cur_addr_reg <= need_prefix ? ON_ADDR[0] : addr_reg;
                     cur_data_reg <= need_prefix ? ON_DATA[0] : wdata_reg;
                     done_reg <= 1'b0;
                     state_reg <= S_SETUP;
                  end else begin
                     refused_reg <= 1'b1;
                  end
               end else if (go && (op == OP_LOCK_ON ||
                                   op == OP_LOCK_OFF)) begin
                  if (por_done && !load_open) begin
                     seq_reg <= 1'b1;
                     on_op_reg <= op == OP_LOCK_ON;
                     idx_reg <= 2'h0;
                     cur_addr_reg <= op == OP_LOCK_ON ? ON_ADDR[0]
                                                      : OFF_ADDR[0];
                     cur_data_reg <= op == OP_LOCK_ON ? ON_DATA[0]
                                                      : OFF_DATA[0];
                     state_reg <= S_SETUP;
                  end else begin
                     refused_reg <= 1'b1;
                  end
               end else if (wr && hit_status && pwdata[ST_REFUSED_BIT]) begin
                  refused_reg <= 1'b0;
               end
            end
            S_SETUP: begin
               cnt_reg <= TMR_W'(WP_CYC);
               state_reg <= S_STROBE;
            end
            S_STROBE: begin
               cnt_reg <= cnt_reg - TMR_W'(1);
               if (cnt_end) begin
                  cnt_reg <= TMR_W'(WPH_CYC);
                  state_reg <= S_RECOVER;
               end
            end
            S_RECOVER: begin
               cnt_reg <= cnt_reg - TMR_W'(1);
               if (cnt_end) begin
                  if (!last_byte) begin
                     // next byte follows well inside the window
                     idx_reg <= idx_inc;
                     cur_addr_reg <= nxt_addr;
                     cur_data_reg <= nxt_data;
                     state_reg <= S_SETUP;
                  end else if (seq_reg) begin
                     cnt_reg <= TMR_W'(PROG_CYCLES);
                     state_reg <= S_PROG;
                  end else begin
                     page_reg <= addr_reg;
                     last_data_reg <= wdata_reg;
                     state_reg <= S_IDLE;
                  end
               end
            end
            S_READ: begin
               cnt_reg <= cnt_reg - TMR_W'(1);
               if (cnt_end) begin
                  rdata_reg <= dq_in;
                  prev6_reg <= dq_in[6];
                  prev_ok_reg <= 1'b1;
                  if (poll_reg && !poll_end) begin
                     state_reg <= S_GAP;
                  end else begin
                     done_reg <= poll_reg;
                     state_reg <= S_IDLE;
                  end
               end
            end
            S_GAP: begin
               cnt_reg <= TMR_W'(ACC_CYC);
               state_reg <= S_READ;
            end
            S_PROG: begin
               // lock takes hold only once the timer has run out
               cnt_reg <= cnt_reg - TMR_W'(1);
               if (cnt_end) begin
                  lock_reg <= on_op_reg;
                  state_reg <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // =====================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_strobe_drive;
      !pins.we_n |-> pins.oe_n && !pins.ce_n;
   endproperty
   a_strobe_drive: assert property (p_strobe_drive)
      else $error("write strobe without select or with drive low");

   property p_no_contention;
      pins.dq_oe |-> pins.oe_n;
   endproperty
   a_no_contention: assert property (p_no_contention)
      else $error("host drives data while memory may drive");

   property p_por_block;
      !por_done |-> pins.we_n;
   endproperty
   a_por_block: assert property (p_por_block)
      else $error("write strobe inside power-on hold-off");

   sequence s_strobe_start;
      $fell(pins.we_n);
   endsequence
   sequence s_strobe_hold;
      !pins.we_n [*2] ##1 pins.we_n;
   endsequence
   property p_pulse_width;
      s_strobe_start |-> s_strobe_hold;
   endproperty
   a_pulse_width: assert property (p_pulse_width)
      else $error("write pulse width wrong");

   property p_addr_hold;
      !pins.we_n && $past(!pins.we_n) |-> $stable(pins.addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("address moved during strobe");

   property p_data_hold;
      $rose(pins.we_n) |-> pins.dq_oe && $stable(pins.dq_out);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("data not held at strobe release");

   property p_same_page;
      $fell(pins.we_n) && !seq_reg && idx_reg == 2'(SEQ_LEN) &&
         load_open |->
         pins.addr[ADDR_W-1:PAGE_LSB] == page_reg[ADDR_W-1:PAGE_LSB];
   endproperty
   a_same_page: assert property (p_same_page)
      else $error("page changed within a load");

   property p_window;
      $rose(pins.we_n) |-> win_reg == TMR_W'(BLW_CYC);
   endproperty
   a_window: assert property (p_window)
      else $error("byte-load window not restarted");

   property p_locked_prefix;
      go && op == OP_WRITE && write_ok && lock_reg && !load_open |=>
         pins.addr == ON_ADDR[0] ##2 !pins.we_n;
   endproperty
   a_locked_prefix: assert property (p_locked_prefix)
      else $error("locked write not led by unlock sequence");

   property p_lock_wait;
      state_reg == S_RECOVER && cnt_end && seq_reg && last_byte |=>
         state_reg == S_PROG && lock_reg == $past(lock_reg);
   endproperty
   a_lock_wait: assert property (p_lock_wait)
      else $error("lock changed before programming time");
endmodule

//--- design/eeprom_host_pkg.sv
// Functional notes
// - write is strobe low, select low, drive high
// - host writes next byte within window
// - host keeps page bits fixed per load
// - three-byte sequence enables lock
// - locked writes need sequence before data
// - command bytes follow page-load timing
// - id area reached with id line high
package eeprom_host_pkg;
   // =====================================================
   // bus and memory geometry
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int PAGE_LSB = 7;
   localparam int SEQ_LEN = 3;
   localparam int TMR_W = 24;
   // =====================================================
   // register map, byte addresses
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_ADDR = 8'h08;
   localparam logic [7:0] OFS_WDATA = 8'h0C;
   localparam logic [7:0] OFS_RDATA = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   // ctrl fields
   localparam int CTRL_ID_BIT = 0;
   localparam int CTRL_LOCK_BIT = 1;
   // status fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_POR_BIT = 1;
   localparam int ST_LOAD_BIT = 2;
   localparam int ST_DONE_BIT = 3;
   localparam int ST_REFUSED_BIT = 4;
   localparam int ST_LOCK_BIT = 5;
   // =====================================================
   // command opcodes, low bits of the command register
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_READ = 3'b001,
      OP_WRITE = 3'b010,
      OP_POLL = 3'b011,
      OP_LOCK_ON = 3'b100,
      OP_LOCK_OFF = 3'b101
   } op_type;
   // =====================================================
   // timing in printed units, cycles derived from the clock
   localparam int CLK_NS = 50;
   localparam int WP_NS = 100;
   localparam int WPH_NS = 50;
   localparam int ACC_NS = 120;
   localparam int BLW_US = 150;
   localparam int POR_MS = 5;
   localparam int PROG_MS = 10;
   localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC = (WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int BLW_CYC = (BLW_US * 1000) / CLK_NS;
   localparam int POR_CYC = (POR_MS * 1000000) / CLK_NS;
   localparam int PROG_CYC = (PROG_MS * 1000000) / CLK_NS;
   // =====================================================
   // pins toward the memory, bundled
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe;
      logic id_hv;
   } mem_pins_type;
endpackage

//--- test/eeprom_model.sv
`timescale 1ns/1ps
module eeprom_model
   import eeprom_host_pkg::*;
#(
   parameter int POR_WAIT = 10,
   parameter int BUSY_CYC = 40,
   parameter int WIN_CYC = BLW_CYC,
   // command bytes mirror the host defaults, values arbitrary
   parameter logic [SEQ_LEN-1:0][ADDR_W-1:0] ON_ADDR =
      {17'h00003, 17'h00002, 17'h00001},
   parameter logic [SEQ_LEN-1:0][DATA_W-1:0] ON_DATA =
      {8'h03, 8'h02, 8'h01},
   parameter logic [SEQ_LEN-1:0][ADDR_W-1:0] OFF_ADDR =
      {17'h00006, 17'h00005, 17'h00004},
   parameter logic [SEQ_LEN-1:0][DATA_W-1:0] OFF_DATA =
      {8'h06, 8'h05, 8'h04}
) (
   input wire logic clk,
   input wire mem_pins_type pins,
   output logic [DATA_W-1:0] dq_in
);
   // =====================================================
   // array, page latch and protection state
   logic [DATA_W-1:0] mem [logic [ADDR_W:0]];
   logic [DATA_W-1:0] page [logic [ADDR_W:0]];
   logic [ADDR_W:0] key;
   logic [ADDR_W:0] alat;
   logic [DATA_W-1:0] last_data = 8'h00;
   logic [DATA_W-1:0] dq_q = 8'h5A;
   logic [DATA_W-1:0] rv;
   logic locked = 1'b0;
   logic tog = 1'b0;
   logic act_d = 1'b0;
   logic rd_d = 1'b0;
   logic rd, act, on_hit, off_hit;
   int por = 0, win = 0, busy = 0, on_pos = 0, off_pos = 0;
   // raised id line opens the separate area
   assign key = {pins.id_hv, pins.addr};
   assign rd = !pins.ce_n && !pins.oe_n && pins.we_n;
   assign act = !pins.we_n && !pins.ce_n && pins.oe_n;
   assign dq_in = dq_q;
   // =====================================================
   // byte load: command bytes are never stored
   task automatic take(input logic [ADDR_W:0] a, input logic [7:0] d);
      on_hit = on_pos < SEQ_LEN && a == {1'b0, ON_ADDR[on_pos]}
         && d == ON_DATA[on_pos];
      off_hit = off_pos < SEQ_LEN && a == {1'b0, OFF_ADDR[off_pos]}
         && d == OFF_DATA[off_pos];
      win = WIN_CYC;
      if (on_pos < SEQ_LEN) on_pos = on_hit ? on_pos + 1 : 0;
      if (off_pos < SEQ_LEN) off_pos = off_hit ? off_pos + 1 : 0;
      if (on_hit || off_hit) begin
         return;
      end else if (locked && on_pos < SEQ_LEN) begin
         // a locked plain write is not stored; it only records the byte for polling and runs the timer
         last_data = d;
         win = 0;
         busy = BUSY_CYC;
      end else begin
         page[a] = d;
         last_data = d;
      end
   endtask
   // end of programming: store the page, then update the lock
   task automatic commit();
      if (!locked || on_pos == SEQ_LEN) begin
         foreach (page[k]) mem[k] = page[k];
      end
      if (on_pos == SEQ_LEN) locked = 1'b1;
      if (off_pos == SEQ_LEN) locked = 1'b0;
      page.delete();
      on_pos = 0;
      off_pos = 0;
   endtask
   // =====================================================
   // timers, strobe edges and read drive, one process
   always @(posedge clk) begin
      if (por < POR_WAIT) por = por + 1;
      if (act && !act_d) alat = key;
      if (!act && act_d && por >= POR_WAIT && busy == 0) begin
         take(alat, pins.dq_out);
      end
      act_d = act;
      if (win > 0) begin
         win = win - 1;
         if (win == 0) busy = BUSY_CYC;
      end else if (busy > 0) begin
         busy = busy - 1;
         if (busy == 0) commit();
      end
      tog = tog ^ (rd && !rd_d && busy > 0);
      rd_d = rd;
      rv = mem.exists(key) ? mem[key] : 8'hFF;
      // released lines toggle each cycle, alternating the last byte driven and its complement
      if (!rd) dq_q <= ~dq_q;
      else if (busy > 0) dq_q <= {~last_data[7], tog, rv[5:0]};
      else dq_q <= rv;
   end
endmodule

//--- test/test_eeprom_host.sv
`timescale 1ns/1ps
module test_eeprom_host;
   import eeprom_host_pkg::*;
   typedef struct packed {
      logic [31:0] val;
      logic [31:0] mask;
      logic err;
   } note_type;
   logic clk, reset, psel, penable, pwrite, pslverr, pready, want;
   logic [7:0] paddr;
   logic [7:0] exp_mem [128];
   logic [31:0] pwdata, prdata, rdv;
   logic [DATA_W-1:0] dq_in;
   logic [ADDR_W-1:0] base;
   mem_pins_type pins;
   note_type notes [$];
   note_type cur;
   int mismatches = 0, tests_run = 0;
   // short hold-off and lock wait keep the run brief
   eeprom_host #(.POR_CYCLES(20), .PROG_CYCLES(3100)) DUT (.clk(clk),
      .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dq_in(dq_in), .pins(pins));
   eeprom_model mem_model (.clk(clk), .pins(pins), .dq_in(dq_in));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // =====================================================
   // reporting
   task automatic give_verdict();
      if (mismatches == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      tests_run++;
      if (seen !== expv) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   // =====================================================
   // bus master: request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic c);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      want <= c;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         give_verdict();
      end
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask
   // the note is queued before the access so the watcher finds it
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] v,
         input logic [31:0] m, input logic e);
      notes.push_back('{v, m, e});
      apb(1'b0, a, 32'h0, 1'b1);
   endtask
   task automatic wait_st(input int b, input logic v);
      int n;
      n = 0;
      do begin
         apb(1'b0, OFS_STATUS, 32'h0, 1'b0);
         n++;
      end while (rdv[b] !== v && n < 4000);
      if (n >= 4000) begin
         mismatches++;
         give_verdict();
      end
   endtask
   task automatic op(input op_type o, input logic [16:0] a,
         input logic [7:0] d);
      wr(OFS_ADDR, {15'h0, a});
      wr(OFS_WDATA, {24'h0, d});
      wr(OFS_CMD, {29'h0, o});
      wait_st(ST_BUSY_BIT, 1'b0);
   endtask
   task automatic rd_mem(input logic [16:0] a, input logic [7:0] e);
      op(OP_READ, a, 8'h00);
      rd_chk(OFS_RDATA, {24'h0, e}, 32'hFF, 1'b0);
   endtask
   // watcher: each tagged read takes the oldest note
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && want && notes.size() > 0)
      begin
         cur = notes.pop_front();
         check(prdata & cur.mask, cur.val);
         check({31'h0, pslverr}, {31'h0, cur.err});
      end
   end
   // =====================================================
   // main sequence
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      want = 1'b0;
      reset = 1'b1;
      void'($urandom(82207));
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd_chk(OFS_STATUS, 32'h0, 32'h3F, 1'b0);
      rd_chk(8'h40, 32'h0, 32'h0, 1'b1);
      op(OP_WRITE, 17'h00100, 8'h11);
      rd_chk(OFS_STATUS, 32'h10, 32'h10, 1'b0);
      wr(OFS_STATUS, 32'h10);
      wait_st(ST_POR_BIT, 1'b1);
      // full page loaded top down, one byte overwritten at the end
      base = 17'($urandom_range(1, 1000)) << 7;
      for (int i = 127; i >= 0; i--) begin
         exp_mem[i] = 8'($urandom());
         op(OP_WRITE, base | 17'(i), exp_mem[i]);
      end
      exp_mem[5] = 8'($urandom()) & 8'h7F;
      op(OP_WRITE, base | 17'd5, exp_mem[5]);
      op(OP_WRITE, base + 17'h80, 8'h00);
      rd_chk(OFS_STATUS, 32'h14, 32'h14, 1'b0);
      wr(OFS_STATUS, 32'h10);
      op(OP_POLL, base | 17'd5, 8'h00);
      rd_chk(OFS_STATUS, 32'h08, 32'h0D, 1'b0);
      for (int i = 0; i < 128; i++) rd_mem(base | 17'(i), exp_mem[i]);
      rd_mem(base + 17'h80, 8'hFF);
      wr(OFS_CTRL, 32'h1);
      op(OP_WRITE, 17'h1FF85, 8'h2C);
      op(OP_POLL, 17'h1FF85, 8'h00);
      rd_mem(17'h1FF85, 8'h2C);
      wr(OFS_CTRL, 32'h0);
      rd_mem(17'h1FF85, 8'hFF);
      // lock on, unlocked write, plain write refused by the device
      op(OP_LOCK_ON, 17'h0, 8'h00);
      rd_chk(OFS_STATUS, 32'h20, 32'h21, 1'b0);
      wr(OFS_CTRL, 32'h2);
      op(OP_WRITE, 17'h00050, 8'h35);
      op(OP_POLL, 17'h00050, 8'h00);
      rd_mem(17'h00050, 8'h35);
      rd_mem(17'h00001, 8'hFF);
      wr(OFS_CTRL, 32'h0);
      op(OP_WRITE, 17'h00060, 8'hA5);
      op(OP_POLL, 17'h00060, 8'h00);
      rd_mem(17'h00060, 8'hFF);
      wait_st(ST_LOAD_BIT, 1'b0);
      op(OP_LOCK_OFF, 17'h0, 8'h00);
      rd_chk(OFS_STATUS, 32'h0, 32'h21, 1'b0);
      op(OP_WRITE, 17'h00060, 8'hA5);
      // old and new bit seven agree, so poll only once programming runs
      wait_st(ST_LOAD_BIT, 1'b0);
      op(OP_POLL, 17'h00060, 8'h00);
      rd_mem(17'h00060, 8'hA5);
      give_verdict();
   end
endmodule
